/* File: hw/fault_flag_pkg.sv */
// Shared constants and carriers for the fault flag routing block
package fault_flag_pkg;

   localparam int unsigned        CHANNELS          = 4;
   localparam logic [7:0]         ROUTING_OFFSET    = 8'h81;
   localparam logic [7:0]         ROUTING_RESET     = 8'h00;
   localparam logic [7:0]         ROUTING_USED_MASK = 8'h1F;
   localparam logic [7:0]         READ_UNMAPPED     = 8'h00;
   localparam int unsigned        SYNC_STAGES       = 2;

   // Routing register layout, bit 7 down to bit 0
   typedef struct packed {
      logic [2:0] unused;
      logic       supply_range_pass;
      logic       battery_short_pass;
      logic       open_load_pass;
      logic       current_limit_pass;
      logic       thermal_shutdown_pass;
   } routing_t;

   // One bit per output channel for each driver fault type
   typedef struct packed {
      logic [CHANNELS-1:0] battery_short_fault;
      logic [CHANNELS-1:0] open_load_fault;
      logic [CHANNELS-1:0] current_limit_fault;
      logic [CHANNELS-1:0] thermal_shutdown_fault;
   } channel_faults_t;

   // Under and over voltage monitors of both supply inputs
   typedef struct packed {
      logic supply_input_a_uv;
      logic supply_input_a_ov;
      logic supply_input_b_uv;
      logic supply_input_b_ov;
   } supply_status_t;

endpackage : fault_flag_pkg

/* File: hw/fault_flag_routing.sv */
// Fault flag routing: routing register, diagnostic persistence and open-drain flag
// Contract
// [R1] Routing register at 0x81 reads back writes
// [R2] Power-on reset or wake loads 0x00
// [R3] Bit 3 gates battery short of any channel
// [R4] Bit 2 gates open load of any channel
// [R5] Bit 1 gates current limit of any channel
// [R6] OR each type over channels; bit 0 thermal
// [R7] Bit 4 gates any supply under/over voltage
// [R8] Flag low while passed category active, else released
// [R9] Flag follows persistence of diagnostic bits
// [R10] Host isolates fault type by enabling categories
// [R11] Current limit and thermal faults latch until cleared
// [R12] Clear-on-read makes real-time faults latch
// [R13] Bits 7 to 5 ignored, read zero
`timescale 1ns/100ps
`default_nettype none

module fault_flag_routing
(
   input  wire logic                            i_sys_clk,
   input  wire logic                            i_rst,
   input  wire logic                            i_wake,
   input  wire logic [7:0]                      i_reg_addr,
   input  wire logic                            i_reg_wr,
   input  wire logic                            i_reg_rd,
   input  wire logic [7:0]                      i_reg_wdata,
   output logic      [7:0]                      o_reg_rdata,
   input  wire fault_flag_pkg::channel_faults_t i_channel_faults,
   input  wire fault_flag_pkg::supply_status_t  i_supply_status,
   input  wire logic                            i_clear_on_read_capture,
   input  wire logic [fault_flag_pkg::CHANNELS-1:0] i_latched_clear,
   input  wire logic                            i_diag_read_clear,
   output fault_flag_pkg::channel_faults_t      o_diag_state,
   output logic                                 o_fault_flag_n_out,
   output logic                                 o_fault_flag_n_oe
);

   localparam int unsigned NCH = fault_flag_pkg::CHANNELS;

   fault_flag_pkg::routing_t        routing;
   fault_flag_pkg::routing_t        next_routing;
   logic [7:0]                      next_reg_rdata;
   fault_flag_pkg::channel_faults_t chan_sync1;
   fault_flag_pkg::channel_faults_t chan_sync2;
   fault_flag_pkg::supply_status_t  supply_sync1;
   fault_flag_pkg::supply_status_t  supply_sync2;
   fault_flag_pkg::channel_faults_t held;
   fault_flag_pkg::channel_faults_t next_held;
   logic                            supply_held;
   logic                            next_supply_held;
   logic                            supply_now;
   logic                            flag_active;
   logic                            next_flag_oe;

   // Open-drain: the pin is only ever pulled low, never driven high
   assign o_fault_flag_n_out = 1'b0;
   assign o_diag_state       = held;

   // Register port
   always_comb
   begin
      next_routing   = routing;
      next_reg_rdata = o_reg_rdata;
      // [R2] Wake reload
      if (i_wake)
      begin
         next_routing = fault_flag_pkg::routing_t'(fault_flag_pkg::ROUTING_RESET);
      end
      // [R1] Routing write
      // [R13] Unused bits dropped
      else if (i_reg_wr && i_reg_addr == fault_flag_pkg::ROUTING_OFFSET)
      begin
         next_routing = fault_flag_pkg::routing_t'(i_reg_wdata & fault_flag_pkg::ROUTING_USED_MASK);
      end
      if (i_reg_rd)
      begin
         next_reg_rdata = (i_reg_addr == fault_flag_pkg::ROUTING_OFFSET) ? routing
                                                                        : fault_flag_pkg::READ_UNMAPPED;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         routing     <= fault_flag_pkg::routing_t'(fault_flag_pkg::ROUTING_RESET);
         o_reg_rdata <= fault_flag_pkg::READ_UNMAPPED;
      end
      else
      begin
         routing     <= next_routing;
         o_reg_rdata <= next_reg_rdata;
      end
   end

   // Fault monitors are analog and asynchronous to this clock
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         chan_sync1   <= '0;
         chan_sync2   <= '0;
         supply_sync1 <= '0;
         supply_sync2 <= '0;
      end
      else
      begin
         chan_sync1   <= i_channel_faults;
         chan_sync2   <= chan_sync1;
         supply_sync1 <= i_supply_status;
         supply_sync2 <= supply_sync1;
      end
   end

   // Diagnostic persistence; a fault present in the clearing cycle survives the clear
   always_comb
   begin
      supply_now = |supply_sync2;
      // [R11] Latched types hold until the per-channel clear
      next_held.current_limit_fault    = chan_sync2.current_limit_fault
                                       | (held.current_limit_fault & ~i_latched_clear);
      next_held.thermal_shutdown_fault = chan_sync2.thermal_shutdown_fault
                                       | (held.thermal_shutdown_fault & ~i_latched_clear);
      // [R12] Capture real-time types while clear-on-read is set
      if (i_clear_on_read_capture)
      begin
         next_held.battery_short_fault = chan_sync2.battery_short_fault
                                       | (held.battery_short_fault & {NCH{~i_diag_read_clear}});
         next_held.open_load_fault     = chan_sync2.open_load_fault
                                       | (held.open_load_fault & {NCH{~i_diag_read_clear}});
         next_supply_held              = supply_now | (supply_held & ~i_diag_read_clear);
      end
      // [R9] Real-time types track the live condition
      else
      begin
         next_held.battery_short_fault = chan_sync2.battery_short_fault;
         next_held.open_load_fault     = chan_sync2.open_load_fault;
         next_supply_held              = supply_now;
      end
   end

   // Flag combining
   always_comb
   begin
      // [R3] Battery short gate
      // [R4] Open load gate
      // [R5] Current limit gate
      // [R6] OR across channels, thermal gate
      // [R7] Supply range gate
      flag_active = (routing.battery_short_pass    && |held.battery_short_fault)
                 || (routing.open_load_pass        && |held.open_load_fault)
                 || (routing.current_limit_pass    && |held.current_limit_fault)
                 || (routing.thermal_shutdown_pass && |held.thermal_shutdown_fault)
                 || (routing.supply_range_pass     && supply_held);
      // [R8] Pull low while any passed category active
      next_flag_oe = flag_active;
   end

   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         held              <= '0;
         supply_held       <= 1'b0;
         o_fault_flag_n_oe <= 1'b0;
      end
      else
      begin
         held              <= next_held;
         supply_held       <= next_supply_held;
         o_fault_flag_n_oe <= next_flag_oe;
      end
   end

   // Checks
   sequence routing_write_s;
      i_reg_wr && !i_wake && i_reg_addr == fault_flag_pkg::ROUTING_OFFSET;
   endsequence

   sequence routing_read_s;
      i_reg_rd && !i_reg_wr && !i_wake && i_reg_addr == fault_flag_pkg::ROUTING_OFFSET;
   endsequence

   reg_readback_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R1]
      routing_write_s ##1 routing_read_s |=> o_reg_rdata == ($past(i_reg_wdata, 2) & 8'h1F))
      else $error("routing read does not return last write");

   wake_clear_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R2]
      i_wake ##1 (i_reg_rd && i_reg_addr == fault_flag_pkg::ROUTING_OFFSET && !i_wake) |=> o_reg_rdata == 8'h00)
      else $error("wake did not clear routing register");

   unused_zero_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R13]
      o_reg_rdata[7:5] == 3'b000)
      else $error("unused routing bits read nonzero");

   short_pass_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R3]
      routing.battery_short_pass && |held.battery_short_fault |=> o_fault_flag_n_oe)
      else $error("passed battery short did not pull flag");

   open_pass_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R4]
      routing.open_load_pass && |held.open_load_fault |=> o_fault_flag_n_oe)
      else $error("passed open load did not pull flag");

   limit_pass_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R5]
      routing.current_limit_pass && |held.current_limit_fault |=> o_fault_flag_n_oe)
      else $error("passed current limit did not pull flag");

   thermal_pass_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R6]
      routing.thermal_shutdown_pass && |held.thermal_shutdown_fault |=> o_fault_flag_n_oe)
      else $error("passed thermal shutdown did not pull flag");

   supply_pass_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R7]
      routing.supply_range_pass && supply_held |=> o_fault_flag_n_oe)
      else $error("passed supply fault did not pull flag");

   flag_cause_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R8]
      o_fault_flag_n_oe == $past(flag_active))
      else $error("flag does not match passed faults");

   latch_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R11]
      1'b1 |=> (($past(held.current_limit_fault) & ~$past(i_latched_clear)) & ~held.current_limit_fault) == '0)
      else $error("latched current limit lost without clear");

   thermal_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R11]
      1'b1 |=> (($past(held.thermal_shutdown_fault) & ~$past(i_latched_clear))
                & ~held.thermal_shutdown_fault) == '0)
      else $error("latched thermal shutdown lost without clear");

   cor_capture_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R12]
      i_clear_on_read_capture && !i_diag_read_clear && |held.open_load_fault
      |=> (held.open_load_fault & $past(held.open_load_fault)) == $past(held.open_load_fault))
      else $error("captured open load lost before read");

   realtime_follow_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R9]
      !i_clear_on_read_capture |=> held.battery_short_fault == $past(chan_sync2.battery_short_fault))
      else $error("real-time battery short does not track condition");

endmodule : fault_flag_routing

`default_nettype wire

/* File: tb/fault_host_model.sv */
// Host side model: pull-up on the open-drain fault line and a sampled copy
`timescale 1ns/100ps
`default_nettype none

module fault_host_model
(
   input  wire logic i_sys_clk,
   input  wire logic i_flag_out,
   input  wire logic i_flag_oe,
   output logic      o_line_seen
);
   logic line;

   // Released line floats up through the pull-up
   assign line = i_flag_oe ? i_flag_out : 1'h1;

   // Host samples the flag each cycle
   always_ff @(posedge i_sys_clk)
      o_line_seen <= line;
endmodule : fault_host_model
`default_nettype wire

/* File: tb/test_fault_flag_routing.sv */
// Self-checking bench for the fault flag routing block
`timescale 1ns/100ps
`default_nettype none

module test_fault_flag_routing;
   typedef struct packed {
      logic [7:0]  routing;
      logic [15:0] faults;
      logic [3:0]  supply;
      logic        line;
   } row_t;

   logic                            i_sys_clk = 1'h0;
   logic                            i_rst = 1'h1;
   logic                            i_wake = 1'h0;
   logic [7:0]                      i_reg_addr = 8'h00;
   logic                            i_reg_wr = 1'h0;
   logic                            i_reg_rd = 1'h0;
   logic [7:0]                      i_reg_wdata = 8'h00;
   logic [7:0]                      o_reg_rdata;
   fault_flag_pkg::channel_faults_t i_channel_faults = '0;
   fault_flag_pkg::supply_status_t  i_supply_status = '0;
   logic                            i_clear_on_read_capture = 1'h0;
   logic [3:0]                      i_latched_clear = 4'h0;
   logic                            i_diag_read_clear = 1'h0;
   fault_flag_pkg::channel_faults_t o_diag_state;
   logic                            flag_out;
   logic                            flag_oe;
   logic                            line_seen;
   logic [7:0]                      rd;
   int                              num_errors = 0;
   int                              cmp_count = 0;
   int                              cycles = 0;
   // One category passed at a time, or all but one
   row_t rows [11] = '{{8'h08,16'h4000,4'h0,1'h0}, {8'h17,16'h1000,4'h0,1'h1}, {8'h04,16'h0800,4'h0,1'h0},
      {8'h1B,16'h0200,4'h0,1'h1}, {8'h02,16'h0080,4'h0,1'h0}, {8'h1D,16'h0080,4'h0,1'h1},
      {8'h01,16'h0001,4'h0,1'h0}, {8'h1E,16'h0008,4'h0,1'h1}, {8'h10,16'h0000,4'h2,1'h0},
      {8'h0F,16'h0000,4'h8,1'h1}, {8'h10,16'h0000,4'h1,1'h0}};

   always #50 i_sys_clk = ~i_sys_clk;

   fault_flag_routing DUT (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_wake(i_wake), .i_reg_addr(i_reg_addr),
      .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
      .i_channel_faults(i_channel_faults), .i_supply_status(i_supply_status),
      .i_clear_on_read_capture(i_clear_on_read_capture), .i_latched_clear(i_latched_clear),
      .i_diag_read_clear(i_diag_read_clear), .o_diag_state(o_diag_state),
      .o_fault_flag_n_out(flag_out), .o_fault_flag_n_oe(flag_oe));

   fault_host_model host (.i_sys_clk(i_sys_clk), .i_flag_out(flag_out), .i_flag_oe(flag_oe),
      .o_line_seen(line_seen));

   task automatic finish_test();
      $display("errors %0d comparisons %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : finish_test

   task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : check_byte

   // Sample a little after the edge so the host copy has settled
   task automatic check_line(input string name, input logic exp);
      #1;
      check_byte(name, {7'h00, exp}, {7'h00, line_seen});
   endtask : check_line

   task automatic wait_cycles(input int n);
      repeat (n) @(posedge i_sys_clk);
   endtask : wait_cycles

   task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
      @(posedge i_sys_clk);
      i_reg_wr <= 1'h1;
      i_reg_addr <= addr;
      i_reg_wdata <= data;
      @(posedge i_sys_clk) i_reg_wr <= 1'h0;
   endtask : reg_write

   task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
      @(posedge i_sys_clk);
      i_reg_rd <= 1'h1;
      i_reg_addr <= addr;
      @(posedge i_sys_clk) i_reg_rd <= 1'h0;
      #1 data = o_reg_rdata;
   endtask : reg_read

   // Drop every condition, then clear what latched once the sync stages have emptied
   task automatic settle();
      @(posedge i_sys_clk);
      i_channel_faults <= '0;
      i_supply_status <= '0;
      wait_cycles(4);
      i_latched_clear <= 4'hF;
      i_diag_read_clear <= 1'h1;
      @(posedge i_sys_clk);
      i_latched_clear <= 4'h0;
      i_diag_read_clear <= 1'h0;
      wait_cycles(5);
   endtask : settle

   always @(posedge i_sys_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         num_errors++;
         finish_test();
      end
   end

   initial
   begin
      wait_cycles(6);
      i_rst <= 1'h0;
      reg_read(8'h81, rd);
      check_byte("routing after reset", 8'h00, rd);
      check_line("flag after reset", 1'h1);
      foreach (rows[k])
      begin
         reg_write(8'h81, rows[k].routing);
         @(posedge i_sys_clk);
         i_channel_faults <= rows[k].faults;
         i_supply_status <= rows[k].supply;
         wait_cycles(7);
         check_line("flag row", rows[k].line);
         settle();
         check_line("flag idle", 1'h1);
      end
      reg_write(8'h81, 8'hFF);
      reg_read(8'h81, rd);
      check_byte("routing unused bits", 8'h1F, rd);
      reg_write(8'h80, 8'h0A);
      reg_read(8'h82, rd);
      check_byte("unmapped read", 8'h00, rd);
      reg_read(8'h81, rd);
      check_byte("routing kept", 8'h1F, rd);
      // Read strobe right behind the write strobe must already see the new value
      @(posedge i_sys_clk);
      i_reg_wr <= 1'h1;
      i_reg_addr <= 8'h81;
      i_reg_wdata <= 8'hE9;
      @(posedge i_sys_clk);
      i_reg_wr <= 1'h0;
      i_reg_rd <= 1'h1;
      @(posedge i_sys_clk) i_reg_rd <= 1'h0;
      #1 check_byte("read right after write", 8'h09, o_reg_rdata);
      // Read in the cycle after the wake pulse, routing is nonzero before it
      @(posedge i_sys_clk) i_wake <= 1'h1;
      @(posedge i_sys_clk);
      i_wake <= 1'h0;
      i_reg_rd <= 1'h1;
      i_reg_addr <= 8'h81;
      @(posedge i_sys_clk) i_reg_rd <= 1'h0;
      #1 check_byte("routing after wake", 8'h00, o_reg_rdata);
      reg_write(8'h81, 8'h02);
      @(posedge i_sys_clk) i_channel_faults <= 16'h0040;
      wait_cycles(7);
      @(posedge i_sys_clk) i_channel_faults <= '0;
      wait_cycles(7);
      check_line("current limit held", 1'h0);
      check_byte("diag held", 8'h40, o_diag_state[7:0]);
      @(posedge i_sys_clk) i_latched_clear <= 4'h4;
      @(posedge i_sys_clk) i_latched_clear <= 4'h0;
      wait_cycles(5);
      check_line("current limit cleared", 1'h1);
      @(posedge i_sys_clk) i_clear_on_read_capture <= 1'h1;
      reg_write(8'h81, 8'h14);
      @(posedge i_sys_clk) i_channel_faults <= 16'h0100;
      wait_cycles(3);
      @(posedge i_sys_clk) i_channel_faults <= '0;
      wait_cycles(7);
      check_line("open load captured", 1'h0);
      @(posedge i_sys_clk) i_diag_read_clear <= 1'h1;
      @(posedge i_sys_clk) i_diag_read_clear <= 1'h0;
      wait_cycles(5);
      check_line("capture cleared", 1'h1);
      @(posedge i_sys_clk) i_supply_status <= 4'h4;
      wait_cycles(3);
      @(posedge i_sys_clk) i_supply_status <= '0;
      wait_cycles(7);
      check_line("supply captured", 1'h0);
      @(posedge i_sys_clk) i_diag_read_clear <= 1'h1;
      @(posedge i_sys_clk) i_diag_read_clear <= 1'h0;
      wait_cycles(5);
      check_line("supply capture cleared", 1'h1);
      // Reset in mid-run while a passed fault pulls the flag
      @(posedge i_sys_clk) i_channel_faults <= 16'h0100;
      wait_cycles(6);
      check_line("open load before reset", 1'h0);
      @(posedge i_sys_clk) i_rst <= 1'h1;
      @(posedge i_sys_clk) i_rst <= 1'h0;
      reg_read(8'h81, rd);
      check_byte("routing after second reset", 8'h00, rd);
      check_line("flag after second reset", 1'h1);
      finish_test();
   end
endmodule : test_fault_flag_routing
`default_nettype wire
